// file: rtl/pvic_map.svh
`ifndef PVIC_MAP_SVH
`define PVIC_MAP_SVH
// ----------------------------------------
// Device register offsets and fields
// ----------------------------------------
`define PVIC_DEV_CTRL 8'h00
`define PVIC_DEV_STAT 8'h04
`define PVIC_DEV_PIX 8'h08
`define PVIC_CTRL_OVR 0
`define PVIC_CTRL_EDGE 1
`define PVIC_CTRL_SWING 2
`define PVIC_CTRL_CFG 3
`define PVIC_DEV_CTRL_RST 5'h00
// ----------------------------------------
// Source register offsets and fields
// ----------------------------------------
`define PVIC_SRC_PIX 8'h00
`define PVIC_SRC_CTL 8'h04
`define PVIC_SRC_CFG 8'h08
`define PVIC_SRC_STAT 8'h0C
`define PVIC_SCFG_EDGE 0
`define PVIC_SCFG_SWING 1
`define PVIC_SCFG_CFG 2
`define PVIC_SCFG_PDN 4
`define PVIC_SRC_CFG_RST 5'h11
// ----------------------------------------
// Timing counts, in pixel clock cycles; PVIC_PIX_HALF in core clock cycles
// ----------------------------------------
`define PVIC_FILT_MIN 3
`define PVIC_TOG_WIN 130
`define PVIC_DEHS_TOG 2
`define PVIC_VS_TOG 1
`define PVIC_PIX_HALF 1
`endif

// file: rtl/pvic_pkg.sv
package pvic_pkg;
  // ----------------------------------------
  // Link configuration codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PVIC_CFG_FILT_OFF = 2'h0,
    PVIC_CFG_FILT_ON = 2'h1,
    PVIC_CFG_COMPAT_A = 2'h2,
    PVIC_CFG_COMPAT_B = 2'h3
  } pvic_cfg_e;
  // ----------------------------------------
  // Device power state, one-hot
  // ----------------------------------------
  typedef enum logic [1:0] {
    PVIC_PWR_DOWN = 2'b01,
    PVIC_PWR_RUN = 2'b10
  } pvic_pwr_e;
  typedef logic [23:0] pvic_pix_t;
endpackage : pvic_pkg

// file: rtl/pvic_if.sv
`timescale 1ns/100ps
// ----------------------------------------
// Parallel pixel pins between source and device
// ----------------------------------------
interface pvic_if;
  logic [23:0] pixel_data_in; // Blue 23:16, green 15:8, red 7:0
  logic data_enable_in;
  logic hsync_in;
  logic vsync_in;
  logic pixel_clock_in;
  logic capture_edge_select; // 1 rising, 0 falling
  logic power_down_n; // Low powers the device down
  logic swing_select; // 1 large swing
  logic [1:0] link_config;
  modport source (
    output pixel_data_in, data_enable_in, hsync_in, vsync_in, pixel_clock_in,
    output capture_edge_select, power_down_n, swing_select, link_config
  );
  modport device (
    input pixel_data_in, data_enable_in, hsync_in, vsync_in, pixel_clock_in,
    input capture_edge_select, power_down_n, swing_select, link_config
  );
endinterface : pvic_if

// file: rtl/pvic_ctl_filter.sv
`timescale 1ns/100ps
// ----------------------------------------
// Control pulse filter, one lane per control input
// ----------------------------------------
module pvic_ctl_filter #(
  parameter int NUM_CH = 2,
  parameter int MIN_W = 3
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic strobe_i,
  input wire logic enable_i,
  input wire logic [NUM_CH-1:0] raw_i,
  output logic [NUM_CH-1:0] filt_o
);
  localparam int CW = $clog2(MIN_W + 1);
  localparam logic [CW-1:0] MIN_C = CW'(MIN_W);

  typedef struct packed {
    logic [NUM_CH-1:0] cand; // Level being timed
    logic [NUM_CH-1:0][CW-1:0] cnt; // Samples seen at that level
    logic [NUM_CH-1:0] filt; // Forwarded level
  } pvic_filt_s;

  pvic_filt_s cur_ff;
  pvic_filt_s nxt_cur;

  // ----------------------------------------
  // Next state, per lane
  // ----------------------------------------
  always_comb begin
    logic [CW-1:0] nc;
    nc = '0;
    nxt_cur = cur_ff;
    for (int i = 0; i < NUM_CH; i++) begin
      if (strobe_i) begin
        // A new level restarts the run count
        if (raw_i[i] != cur_ff.cand[i]) begin
          nc = CW'(1);
        end else if (cur_ff.cnt[i] < MIN_C) begin
          nc = cur_ff.cnt[i] + CW'(1);
        end else begin
          nc = cur_ff.cnt[i];
        end
        nxt_cur.cand[i] = raw_i[i];
        nxt_cur.cnt[i] = nc;
        if (!enable_i) begin
          nxt_cur.filt[i] = raw_i[i];
        end else if (nc >= MIN_C) begin
          nxt_cur.filt[i] = raw_i[i];
        end
        // Short runs leave the forwarded level as it was
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign filt_o = cur_ff.filt;
endmodule : pvic_ctl_filter

// file: rtl/pvic_device.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "pvic_map.svh"

// Behaviour
// - Data bits 7:0 carry red
// - Data bits 15:8 carry green
// - Data bits 23:16 carry blue
// - Controls are enable, hsync, vsync
// - Filter on: enable/hsync pulses under three dropped
// - Filter off: every transition forwarded
// - Enable/hsync toggle twice per 130 cycles
// - Vsync toggles once per 130 cycles
// - Sample all inputs on selected edge
// - Edge select 1 rising, 0 falling
// - Config selects filter or compat modes
// - Power-down high: normal capture
// - Power-down low: stop, lines high, reset
// - Swing select 1 large, 0 small
module pvic_device
  import pvic_pkg::*;
#(
  parameter int FILT_MIN = `PVIC_FILT_MIN
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  pvic_if.device link,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic [23:0] pix_data_o,
  output logic pix_valid_o,
  output logic de_o,
  output logic hs_o,
  output logic vs_o,
  output logic ser_p_o,
  output logic ser_n_o,
  output logic pll_run_o,
  output logic swing_large_o,
  output logic [1:0] link_mode_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pvic_pwr_e pwr; // Power state
    logic [4:0] ctrl; // Control register
    logic pclk_prev; // Pixel clock one sample ago
    pvic_pix_t pix_cap; // Pixel word at the last capture
    logic vs_cap; // Vsync at the last capture
    logic cap_stb; // A capture happened last cycle
    pvic_pix_t pix; // Output pixel
    logic valid; // Output strobe
    logic de; // Forwarded data enable
    logic hs; // Forwarded hsync
    logic vs; // Forwarded vsync
    logic ser_p; // Serial line, true side
    logic ser_n; // Serial line, inverted side
    logic pll; // Clock multiplier running
    logic swing; // Large swing chosen
    logic [1:0] mode; // Active link mode
    logic [31:0] rdata; // Read data
  } pvic_dev_s;

  pvic_dev_s cur_ff;
  pvic_dev_s nxt_cur;

  // Settings as seen by the logic
  logic eff_edge;
  logic eff_swing;
  logic [1:0] eff_cfg;
  logic run;
  logic cap_now;
  logic filt_en;
  logic filt_rstn;
  logic [1:0] filt_q;

  // ----------------------------------------
  // Setting selection
  // ----------------------------------------
  // The override bit lets software take the edge, swing and config pins' place;
  // the pins steer the block while it is clear, as after reset.
  always_comb begin
    if (cur_ff.ctrl[`PVIC_CTRL_OVR]) begin
      eff_edge = cur_ff.ctrl[`PVIC_CTRL_EDGE];
      eff_swing = cur_ff.ctrl[`PVIC_CTRL_SWING];
      eff_cfg = cur_ff.ctrl[`PVIC_CTRL_CFG +: 2];
    end else begin
      eff_edge = link.capture_edge_select;
      eff_swing = link.swing_select;
      eff_cfg = link.link_config;
    end
  end

  // ----------------------------------------
  // Capture strobe
  // ----------------------------------------
  // The pixel clock is a plain input sampled on the core clock, so the
  // core must run at least twice as fast as the pixel clock.
  always_comb begin
    run = link.power_down_n;
    if (eff_edge) begin
      cap_now = run && link.pixel_clock_in && !cur_ff.pclk_prev;
    end else begin
      cap_now = run && !link.pixel_clock_in && cur_ff.pclk_prev;
    end
    // Only the filter-on code imposes a least pulse width
    filt_en = (eff_cfg == PVIC_CFG_FILT_ON);
    filt_rstn = resetn_i && link.power_down_n;
  end

  // ----------------------------------------
  // Enable and hsync filter
  // ----------------------------------------
  // Vsync bypasses it: its pulses are at least 130 cycles long.
  pvic_ctl_filter #(
    .NUM_CH(2),
    .MIN_W(FILT_MIN)
  ) u_filter (
    .core_clk_i(core_clk_i),
    .resetn_i(filt_rstn),
    .strobe_i(cap_now),
    .enable_i(filt_en),
    .raw_i({link.hsync_in, link.data_enable_in}),
    .filt_o(filt_q)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.pclk_prev = link.pixel_clock_in;
    nxt_cur.cap_stb = cap_now;

    // Power state follows the power-down input directly
    case (cur_ff.pwr)
      PVIC_PWR_DOWN: begin
        if (link.power_down_n) begin
          nxt_cur.pwr = PVIC_PWR_RUN;
        end
      end
      PVIC_PWR_RUN: begin
        if (!link.power_down_n) begin
          nxt_cur.pwr = PVIC_PWR_DOWN;
        end
      end
      default: begin
        nxt_cur.pwr = PVIC_PWR_DOWN;
      end
    endcase

    // Sample the whole word and vsync together on the chosen edge
    if (cap_now) begin
      nxt_cur.pix_cap = link.pixel_data_in;
      nxt_cur.vs_cap = link.vsync_in;
    end

    // Data and controls leave together, two cycles after capture,
    // which lines the word up with the registered filter output.
    nxt_cur.pix = cur_ff.pix_cap;
    nxt_cur.valid = cur_ff.cap_stb;
    nxt_cur.de = filt_q[0];
    nxt_cur.hs = filt_q[1];
    nxt_cur.vs = cur_ff.vs_cap;
    nxt_cur.swing = eff_swing;
    nxt_cur.mode = eff_cfg;

    // Serial lines: the encoder lives elsewhere; here they only mark
    // capture activity, and both park high while powered down.
    if (!run) begin
      nxt_cur.ser_p = 1'b1;
      nxt_cur.ser_n = 1'b1;
      nxt_cur.pll = 1'b0;
    end else begin
      nxt_cur.pll = 1'b1;
      if (cap_now) begin
        nxt_cur.ser_p = ~cur_ff.ser_p;
        nxt_cur.ser_n = cur_ff.ser_p;
      end else if (cur_ff.ser_p == cur_ff.ser_n) begin
        // Leaving power-down: restore a differential pair
        nxt_cur.ser_n = ~cur_ff.ser_p;
      end
    end

    // Control register write; power-down holds it at reset value
    if (!run) begin
      nxt_cur.ctrl = `PVIC_DEV_CTRL_RST;
    end else if (reg_we_i && reg_addr_i == `PVIC_DEV_CTRL) begin
      nxt_cur.ctrl = reg_wdata_i[4:0];
    end

    // Read data stands for exactly the cycle after the read strobe
    nxt_cur.rdata = 32'h0;
    if (reg_re_i) begin
      case (reg_addr_i)
        `PVIC_DEV_CTRL: begin
          nxt_cur.rdata = {27'h0, cur_ff.ctrl};
        end
        `PVIC_DEV_STAT: begin
          nxt_cur.rdata = {24'h0, cur_ff.pll, eff_cfg, eff_swing, eff_edge,
                           cur_ff.vs, cur_ff.hs, cur_ff.de};
        end
        `PVIC_DEV_PIX: begin
          nxt_cur.rdata = {8'h0, cur_ff.pix};
        end
        default: begin
          nxt_cur.rdata = 32'h0; // Unmapped reads as zero
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cur_ff <= '{
        pwr: PVIC_PWR_DOWN,
        ctrl: `PVIC_DEV_CTRL_RST,
        ser_p: 1'b1,
        ser_n: 1'b1,
        default: '0
      };
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------
  assign reg_rdata_o = cur_ff.rdata;
  assign pix_data_o = cur_ff.pix;
  assign pix_valid_o = cur_ff.valid;
  assign de_o = cur_ff.de;
  assign hs_o = cur_ff.hs;
  assign vs_o = cur_ff.vs;
  assign ser_p_o = cur_ff.ser_p;
  assign ser_n_o = cur_ff.ser_n;
  assign pll_run_o = cur_ff.pll;
  assign swing_large_o = cur_ff.swing;
  assign link_mode_o = cur_ff.mode;
endmodule : pvic_device

// file: rtl/pvic_source.sv
`timescale 1ns/100ps
`include "pvic_map.svh"

// ----------------------------------------
// Pixel source: makes the pixel clock and drives pins
// ----------------------------------------
module pvic_source
  import pvic_pkg::*;
#(
  parameter int PIX_HALF = `PVIC_PIX_HALF
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  pvic_if.source link,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o
);
  // Least launches between toggles of one control pin
  localparam logic [7:0] GAP_DEHS = 8'(`PVIC_TOG_WIN / `PVIC_DEHS_TOG + 1);
  localparam logic [7:0] GAP_VS = 8'(`PVIC_TOG_WIN / `PVIC_VS_TOG);
  localparam logic [7:0] HALF_C = 8'(PIX_HALF - 1);

  typedef struct packed {
    logic [7:0] div; // Half period counter
    logic pclk; // Pixel clock pin
    pvic_pix_t pix_req; // Pixel to send next
    logic [2:0] ctl_req; // Wanted vsync, hsync, enable
    logic [4:0] cfg; // Configuration pins
    logic [2:0][7:0] gap; // Launches since each pin toggled
    pvic_pix_t pix; // Pixel pins
    logic [2:0] ctl; // Control pins
    logic [31:0] rdata; // Read data
  } pvic_src_s;

  pvic_src_s cur_ff;
  pvic_src_s nxt_cur;
  logic launch;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Pins change on the edge opposite the capture edge, so they stand
  // still for half a pixel period before the device samples them.
  always_comb begin
    nxt_cur = cur_ff;
    launch = 1'b0;
    if (cur_ff.div == HALF_C) begin
      nxt_cur.div = 8'h0;
      nxt_cur.pclk = ~cur_ff.pclk;
      launch = (~cur_ff.pclk) != cur_ff.cfg[`PVIC_SCFG_EDGE];
    end else begin
      nxt_cur.div = cur_ff.div + 8'h1;
    end
    if (launch) begin
      nxt_cur.pix = cur_ff.pix_req;
      for (int i = 0; i < 3; i++) begin
        if (cur_ff.gap[i] != 8'hFF) begin
          nxt_cur.gap[i] = cur_ff.gap[i] + 8'h1;
        end
        // A toggle waits until the pin has rested long enough
        if (cur_ff.ctl_req[i] != cur_ff.ctl[i] &&
            cur_ff.gap[i] >= ((i == 2) ? GAP_VS : GAP_DEHS)) begin
          nxt_cur.ctl[i] = cur_ff.ctl_req[i];
          nxt_cur.gap[i] = 8'h1;
        end
      end
    end
    if (reg_we_i) begin
      case (reg_addr_i)
        `PVIC_SRC_PIX: nxt_cur.pix_req = reg_wdata_i[23:0];
        `PVIC_SRC_CTL: nxt_cur.ctl_req = reg_wdata_i[2:0];
        `PVIC_SRC_CFG: nxt_cur.cfg = reg_wdata_i[4:0];
        default: nxt_cur.cfg = cur_ff.cfg;
      endcase
    end
    nxt_cur.rdata = 32'h0;
    if (reg_re_i) begin
      case (reg_addr_i)
        `PVIC_SRC_PIX: nxt_cur.rdata = {8'h0, cur_ff.pix_req};
        `PVIC_SRC_CTL: nxt_cur.rdata = {29'h0, cur_ff.ctl_req};
        `PVIC_SRC_CFG: nxt_cur.rdata = {27'h0, cur_ff.cfg};
        `PVIC_SRC_STAT: nxt_cur.rdata = {28'h0, cur_ff.pclk, cur_ff.ctl_req ^ cur_ff.ctl};
        default: nxt_cur.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cur_ff <= '{cfg: `PVIC_SRC_CFG_RST, gap: {3{8'hFF}}, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  assign reg_rdata_o = cur_ff.rdata;
  assign link.pixel_data_in = cur_ff.pix;
  assign link.data_enable_in = cur_ff.ctl[0];
  assign link.hsync_in = cur_ff.ctl[1];
  assign link.vsync_in = cur_ff.ctl[2];
  assign link.pixel_clock_in = cur_ff.pclk;
  assign link.capture_edge_select = cur_ff.cfg[`PVIC_SCFG_EDGE];
  assign link.swing_select = cur_ff.cfg[`PVIC_SCFG_SWING];
  assign link.link_config = cur_ff.cfg[`PVIC_SCFG_CFG +: 2];
  assign link.power_down_n = cur_ff.cfg[`PVIC_SCFG_PDN];
endmodule : pvic_source

// file: testbench/pvic_link_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------
// Link checker on the pins and the device outputs
// ----------------------------------------
module pvic_link_asserts (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [23:0] pixel_data_in,
  input wire logic data_enable_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic pixel_clock_in,
  input wire logic capture_edge_select,
  input wire logic power_down_n,
  input wire logic swing_select,
  input wire logic [1:0] link_config,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [23:0] pix_data_o,
  input wire logic pix_valid_o,
  input wire logic de_o,
  input wire logic hs_o,
  input wire logic vs_o,
  input wire logic ser_p_o,
  input wire logic ser_n_o,
  input wire logic pll_run_o,
  input wire logic swing_large_o,
  input wire logic [1:0] link_mode_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic pclk_ff; // Pixel clock one core cycle back
  logic [2:0] de_hist_ff; // Enable level at the last three captures
  logic cap; // Selected pixel clock edge seen in this cycle
  assign cap = power_down_n && (capture_edge_select ? (pixel_clock_in && !pclk_ff)
    : (!pixel_clock_in && pclk_ff));
  // History clears on power-down, because the filter state does too
  always_ff @(posedge core_clk_i) begin
    pclk_ff <= pixel_clock_in;
    if (!resetn_i || !power_down_n) de_hist_ff <= 3'h0;
    else if (cap) de_hist_ff <= {de_hist_ff[1:0], data_enable_in};
  end
  cap_to_valid_a: assert property (
    cap |-> ##2 (pix_valid_o && pix_data_o == $past(pixel_data_in, 2)))
    else $error("captured word not delivered two cycles later");
  valid_cause_a: assert property (
    pix_valid_o |-> $past(cap, 2)) else $error("word delivered without a capture edge");
  vsync_direct_a: assert property (
    pix_valid_o |-> vs_o == $past(vsync_in, 2)) else $error("vsync not passed straight");
  ctl_nofilt_a: assert property (
    pix_valid_o && $past(link_config, 2) != 2'h1 |->
    de_o == $past(data_enable_in, 2) && hs_o == $past(hsync_in, 2))
    else $error("control level not forwarded with filter off");
  filt_enable_a: assert property (
    pix_valid_o && $past(link_config, 2) == 2'h1 && de_o != $past(de_o) |->
    de_hist_ff == {3{de_o}}) else $error("enable changed on a short run");
  pd_lines_a: assert property (
    !power_down_n |=> ser_p_o && ser_n_o && !pll_run_o)
    else $error("power-down state wrong");
  run_lines_a: assert property (
    $past(power_down_n) && power_down_n |=> pll_run_o && (ser_p_o != ser_n_o))
    else $error("running state wrong");
  cfg_follow_a: assert property (
    $past(power_down_n) |-> swing_large_o == $past(swing_select) &&
    link_mode_o == $past(link_config)) else $error("swing or mode not following pins");
  rdata_idle_a: assert property (
    !$past(reg_re_i) |-> reg_rdata_o == 32'h0) else $error("read data outside its cycle");
endmodule : pvic_link_asserts

// file: testbench/test_parallel_video_input_capture.sv
`timescale 1ns/100ps
`include "pvic_map.svh"
// ----------------------------------------
// Bench: source and device face each other
// ----------------------------------------
`define CHK(nm, ex, ac) begin total_checks++; if ((ac) !== (ex)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, ac); end end
module test_parallel_video_input_capture import pvic_pkg::*;;
  logic core_clk_i, resetn_i;
  logic [7:0] bus_addr; // Shared by all three register ports
  logic [31:0] bus_wdata, s_rdata, d_rdata;
  logic s_we, s_re, d_we, d_re, b_we; // Separate strobes pick the port
  logic [23:0] pix_data;
  logic pix_valid, de, hs, vs, ser_p, ser_n, pll_run, swing_large, de_b;
  logic [1:0] link_mode;
  int errors, total_checks, cycles;
  int de_t1 = -1000, de_t2 = -1000, vs_t = -1000; // Cycles of recent pin toggles
  logic de_pin_ff, vs_pin_ff;
  pvic_if pvic_if_inst ();
  pvic_if pvic_if_inst_b (); // Driven by the bench to make short pulses
  pvic_source #(.PIX_HALF(1)) pvic_source_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .link(pvic_if_inst.source), .reg_addr_i(bus_addr), .reg_wdata_i(bus_wdata),
    .reg_we_i(s_we), .reg_re_i(s_re), .reg_rdata_o(s_rdata));
  pvic_device pvic_device_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .link(pvic_if_inst.device), .reg_addr_i(bus_addr), .reg_wdata_i(bus_wdata),
    .reg_we_i(d_we), .reg_re_i(d_re), .reg_rdata_o(d_rdata), .pix_data_o(pix_data),
    .pix_valid_o(pix_valid), .de_o(de), .hs_o(hs), .vs_o(vs), .ser_p_o(ser_p), .ser_n_o(ser_n),
    .pll_run_o(pll_run), .swing_large_o(swing_large), .link_mode_o(link_mode));
  pvic_device pvic_device_inst_b (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .link(pvic_if_inst_b.device), .reg_addr_i(bus_addr), .reg_wdata_i(bus_wdata),
    .reg_we_i(b_we),
    .reg_re_i(1'b0), .reg_rdata_o(), .pix_data_o(), .pix_valid_o(), .de_o(de_b), .hs_o(),
    .vs_o(), .ser_p_o(), .ser_n_o(), .pll_run_o(), .swing_large_o(), .link_mode_o());
  pvic_link_asserts pvic_link_asserts_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .pixel_data_in(pvic_if_inst.pixel_data_in), .data_enable_in(pvic_if_inst.data_enable_in),
    .hsync_in(pvic_if_inst.hsync_in), .vsync_in(pvic_if_inst.vsync_in),
    .pixel_clock_in(pvic_if_inst.pixel_clock_in),
    .capture_edge_select(pvic_if_inst.capture_edge_select),
    .power_down_n(pvic_if_inst.power_down_n), .swing_select(pvic_if_inst.swing_select),
    .link_config(pvic_if_inst.link_config), .reg_re_i(d_re), .reg_rdata_o(d_rdata),
    .pix_data_o(pix_data), .pix_valid_o(pix_valid), .de_o(de), .hs_o(hs), .vs_o(vs),
    .ser_p_o(ser_p), .ser_n_o(ser_n), .pll_run_o(pll_run), .swing_large_o(swing_large),
    .link_mode_o(link_mode));
  // ----------------------------------------
  // Clock, timeout and pin toggle rate watch
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  // Two core cycles per pixel clock, so 130 pixel clocks are 260 cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
    if (resetn_i && de_pin_ff !== pvic_if_inst.data_enable_in) begin
      `CHK("enable rate", 1'b1, (cycles - de_t1 >= 260))
      de_t1 = de_t2;
      de_t2 = cycles;
    end
    if (resetn_i && vs_pin_ff !== pvic_if_inst.vsync_in) begin
      `CHK("vsync rate", 1'b1, (cycles - vs_t >= 260))
      vs_t = cycles;
    end
    de_pin_ff = pvic_if_inst.data_enable_in;
    vs_pin_ff = pvic_if_inst.vsync_in;
  end
  // ----------------------------------------
  // Shared bus and wait tasks
  // ----------------------------------------
  task automatic wr(input bit dv, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus_addr <= a;
    bus_wdata <= d;
    if (dv) d_we <= 1'b1;
    else s_we <= 1'b1;
    @(posedge core_clk_i);
    d_we <= 1'b0;
    s_we <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input bit dv, input logic [7:0] a, input logic [31:0] ex, input string nm);
    @(posedge core_clk_i);
    bus_addr <= a;
    if (dv) d_re <= 1'b1;
    else s_re <= 1'b1;
    @(posedge core_clk_i);
    d_re <= 1'b0;
    s_re <= 1'b0;
    #1;
    `CHK(nm, ex, (dv ? d_rdata : s_rdata))
  endtask : rd
  task automatic wait_pix(input logic [23:0] ex);
    for (int n = 0; n < 100 && !(pix_valid === 1'b1 && pix_data === ex); n++) begin
      @(posedge core_clk_i);
      #1;
    end
    `CHK("pixel", ex, pix_data)
  endtask : wait_pix
  // Bounded, since the source may hold back toggles for many cycles
  task automatic wait_ctl(input logic [2:0] ex);
    for (int n = 0; n < 1000 && {vs, hs, de} !== ex; n++) @(posedge core_clk_i) #1;
    `CHK("controls", ex, {vs, hs, de})
  endtask : wait_ctl
  // One capture on the second link, then look at its enable output
  task automatic cap_b(input logic lvl, input logic ex);
    @(posedge core_clk_i);
    pvic_if_inst_b.pixel_clock_in <= 1'b0;
    pvic_if_inst_b.data_enable_in <= lvl;
    @(posedge core_clk_i);
    pvic_if_inst_b.pixel_clock_in <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    `CHK("filtered enable", ex, de_b)
  endtask : cap_b
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_pixels();
    rd(1'b0, `PVIC_SRC_CFG, 32'h11, "source cfg");
    rd(1'b1, `PVIC_DEV_CTRL, 32'h0, "device ctrl");
    wr(1'b0, `PVIC_SRC_PIX, 32'h00C35A96);
    wait_pix(24'hC35A96);
    `CHK("red pins", 8'h96, pvic_if_inst.pixel_data_in[7:0])
    `CHK("green pins", 8'h5A, pvic_if_inst.pixel_data_in[15:8])
    `CHK("blue pins", 8'hC3, pvic_if_inst.pixel_data_in[23:16])
    rd(1'b1, `PVIC_DEV_PIX, 32'h00C35A96, "device pix");
    wr(1'b0, `PVIC_SRC_CTL, 32'h7);
    wait_ctl(3'h7);
    rd(1'b1, `PVIC_DEV_STAT, 32'h8F, "device stat");
    wr(1'b0, `PVIC_SRC_CFG, 32'h10); // Falling edge capture
    wr(1'b0, `PVIC_SRC_PIX, 32'h00123456);
    wait_pix(24'h123456);
    rd(1'b1, `PVIC_DEV_STAT, 32'h87, "stat falling");
  endtask : test_pixels
  task automatic test_modes();
    for (int m = 0; m < 8; m++) begin
      wr(1'b0, `PVIC_SRC_CFG, 32'h11 | (m << 1));
      repeat (3) @(posedge core_clk_i);
      `CHK("swing", m[0], swing_large)
      `CHK("mode", m[2:1], link_mode)
    end
    wr(1'b0, `PVIC_SRC_CFG, 32'h01); // Power down
    repeat (3) @(posedge core_clk_i);
    `CHK("down lines", 3'h6, {ser_p, ser_n, pll_run})
    wr(1'b1, `PVIC_DEV_CTRL, 32'h1F);
    rd(1'b1, `PVIC_DEV_CTRL, 32'h0, "ctrl held");
    wr(1'b0, `PVIC_SRC_PIX, 32'h00ABCDEF);
    repeat (20) @(posedge core_clk_i);
    `CHK("no capture", 24'h123456, pix_data)
    wr(1'b0, `PVIC_SRC_CFG, 32'h11);
    wait_pix(24'hABCDEF);
  endtask : test_modes
  // Rapid requests: the toggle watch judges the spacing on the pins
  task automatic test_rate();
    wr(1'b0, `PVIC_SRC_CFG, 32'h15); // Filter on, so the checker sees filtered toggles
    wr(1'b0, `PVIC_SRC_CTL, 32'h0);
    wr(1'b0, `PVIC_SRC_CTL, 32'h1);
    wr(1'b0, `PVIC_SRC_CTL, 32'h5);
    wr(1'b0, `PVIC_SRC_CTL, 32'h1);
    wait_ctl(3'h1);
  endtask : test_rate
  // Filter on: a two-capture pulse vanishes, a three-capture level passes
  task automatic test_filter();
    logic [11:0] lv = 12'b000110001111;
    logic [11:0] ex = 12'b000000000011;
    for (int i = 11; i >= 0; i--) begin
      cap_b(lv[i], ex[i]);
      // Two toggles spent: rest before the next, as the source must
      if (i == 6) repeat (130) cap_b(1'b0, 1'b0);
    end
    pvic_if_inst_b.link_config <= PVIC_CFG_FILT_OFF;
    cap_b(1'b0, 1'b0);
    repeat (130) cap_b(1'b0, 1'b0);
    // Pins ask for the filter, the override register turns it off
    pvic_if_inst_b.link_config <= PVIC_CFG_FILT_ON;
    @(posedge core_clk_i);
    bus_addr <= `PVIC_DEV_CTRL;
    bus_wdata <= 32'h3;
    b_we <= 1'b1;
    @(posedge core_clk_i);
    b_we <= 1'b0;
    cap_b(1'b1, 1'b1);
  endtask : test_filter
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    resetn_i = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    {s_we, s_re, d_we, d_re, b_we} = 5'h0;
    pvic_if_inst_b.pixel_data_in = 24'h0;
    {pvic_if_inst_b.data_enable_in, pvic_if_inst_b.hsync_in} = 2'h0;
    {pvic_if_inst_b.vsync_in, pvic_if_inst_b.pixel_clock_in} = 2'h0;
    {pvic_if_inst_b.capture_edge_select, pvic_if_inst_b.power_down_n} = 2'h3;
    pvic_if_inst_b.swing_select = 1'b0;
    pvic_if_inst_b.link_config = PVIC_CFG_FILT_ON;
    repeat (8) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    test_pixels();
    test_modes();
    test_rate();
    test_filter();
    conclude();
  end
endmodule : test_parallel_video_input_capture
